// ---- testbench/spi_far_end.sv ----
// Far side of the serial bus: a slave while the port masters the bus, a master
// while the port is a slave. Assumes the bench calls send_bits and sets reply.
`timescale 1ns/10ps

module spi_far_end #(
  parameter real HALF_NS = 210.0
) (
  input wire logic sck_out,    // Port clock drive
  input wire logic sck_oe,     // Port clock enable
  input wire logic mosi_out,   // Port master-out drive
  input wire logic mosi_oe,    // Port master-out enable
  input wire logic miso_out,   // Port master-in drive
  input wire logic miso_oe,    // Port master-in enable
  input wire logic select_out, // Port select drive
  input wire logic select_oe,  // Port select enable
  input wire logic cpol,       // Shared clock polarity
  input wire logic cpha,       // Shared clock phase
  output logic sck_pin,        // Resolved clock line
  output logic mosi_pin,       // Resolved master-out line
  output logic miso_pin,       // Resolved master-in line
  output logic select_pin      // Resolved select line
);
  logic clk_act, mosi_drv, miso_drv, sel_drv, armed;
  logic [7:0] reply, shreg;
  logic [7:0] got[$];
  int cnt;

  initial begin
    clk_act = 1'b0;
    mosi_drv = 1'b0;
    miso_drv = 1'b0;
    sel_drv = 1'b1;
    armed = 1'b0;
    reply = 8'h00;
    shreg = 8'h00;
    cnt = 0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lines resolved from the port's enables; clock idles at the polarity
  assign sck_pin = sck_oe ? sck_out : (clk_act ^ cpol);
  assign mosi_pin = mosi_oe ? mosi_out : mosi_drv;
  assign miso_pin = miso_oe ? miso_out : miso_drv;
  assign select_pin = select_oe ? select_out : sel_drv;

  // Arm a little after the enable so the idle-level step is not an edge
  always @(sck_oe) begin
    cnt = 0;
    miso_drv = reply[7];
    #1 armed = sck_oe;
  end

  // Slave role: sole slave on the bus, latches on the phase-selected edge
  always @(sck_out) begin
    if (armed === 1'b1 && sck_oe === 1'b1) begin
      if ((sck_out ^ cpol ^ cpha) === 1'b1) begin
        shreg = {shreg[6:0], mosi_out};
        cnt = cnt + 1;
        if (cnt == 8) begin
          got.push_back(shreg);
          cnt = 0;
        end
      end else begin
        miso_drv = reply[7 - cnt];
      end
    end
  end

  // Master role: bit period above ten system cycles, transmit only
  task automatic send_bits(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      if (cpha == 1'b0) mosi_drv = b[7 - i];
      #(HALF_NS) clk_act = 1'b1;
      if (cpha == 1'b1) mosi_drv = b[7 - i];
      #(HALF_NS) clk_act = 1'b0;
    end
    #(HALF_NS) mosi_drv = ~mosi_drv;
  endtask
endmodule

// ---- testbench/spi_port_tb.sv ----
// Self-checking bench for the serial port: master transfers in all four clock modes,
// collision, mode fault, three-wire slave fill and drain. Needs spi_far_end.
`timescale 1ns/10ps

module spi_port_tb;
  import spi_port_pkg::*;
  logic clock, resetn, ctrl_wr, data_wr, rx_ready, event_enable, rx_valid, event_request;
  logic sck_pin, sck_out, sck_oe, mosi_pin, mosi_out, mosi_oe, miso_pin, miso_out, miso_oe;
  logic select_pin, select_out, select_oe;
  ctrl_t ctrl_in, ctrl_out;
  cfg_t cfg;
  flags_t flags, flag_clear;
  logic [7:0] data_in, rx_data, b1, b2;
  logic [7:0] exp_q[$];
  int errors, check_count, seed, n, h;

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  spi_port dut (.clock(clock), .resetn(resetn), .ctrl_wr(ctrl_wr), .ctrl_in(ctrl_in),
    .ctrl_out(ctrl_out), .cfg(cfg), .data_wr(data_wr), .data_in(data_in), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .flags(flags), .flag_clear(flag_clear),
    .event_enable(event_enable), .event_request(event_request), .serial_clk_in(sck_pin),
    .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_pin), .mosi_out(mosi_out),
    .mosi_oe(mosi_oe), .miso_in(miso_pin), .miso_out(miso_out), .miso_oe(miso_oe),
    .slave_select_pin(select_pin), .select_out(select_out), .select_oe(select_oe));

  spi_far_end far (.sck_out(sck_out), .sck_oe(sck_oe), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
    .miso_out(miso_out), .miso_oe(miso_oe), .select_out(select_out), .select_oe(select_oe),
    .cpol(cfg.clock_polarity_bit), .cpha(cfg.clock_phase_bit), .sck_pin(sck_pin),
    .mosi_pin(mosi_pin), .miso_pin(miso_pin), .select_pin(select_pin));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (exp !== got) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop;
    if (errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Inputs always move 1 ns after the rising edge
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask

  task automatic write_ctrl(input ctrl_t c);
    ctrl_in = c;
    ctrl_wr = 1'b1;
    tick(1);
    ctrl_wr = 1'b0;
  endtask

  task automatic clear_flags;
    flag_clear = 4'hF;
    tick(1);
    flag_clear = 4'h0;
  endtask

  // Phase and polarity only change with the port disabled
  task automatic setup(input ctrl_t c, input logic pol, input logic pha, input logic [7:0] rate);
    write_ctrl(4'h0);
    cfg = {pha, pol, rate};
    write_ctrl(c);
  endtask

  // Bounded wait for the byte-done flag; n returns the cycles taken
  task automatic wait_done(output int k);
    k = 0;
    while (flags.transfer_done_flag !== 1'b1) begin
      tick(1);
      k++;
      if (k > 3000) begin
        errors++;
        report_and_stop();
      end
    end
  endtask

  // Scoreboard: each byte popped from the receive FIFO meets its oldest note
  always @(negedge clock) begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      check("rx_data", exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX, rx_data);
    end
  end

  initial begin
    #2_000_000;
    errors++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 19;
    errors = 0;
    check_count = 0;
    {resetn, ctrl_wr, data_wr, rx_ready, event_enable} = 5'h03;
    {ctrl_in, cfg, data_in, flag_clear} = '0;
    tick(20);
    resetn = 1'b1;
    tick(3);
    check("reset state", 8'h00, {ctrl_out, flags});
    // Master bytes in all four phase and polarity settings
    for (int m = 0; m < 4; m++) begin
      far.reply = $random(seed);
      // Half bit of three or more cycles leaves room for the two-flop input path
      setup(4'hE, m[0], m[1], {7'h01, 1'($random(seed))});
      tick(2);
      check("sck idle", {7'h00, m[0]}, {7'h00, sck_out});
      b1 = $random(seed);
      h = cfg.clock_rate + 1;
      exp_q.push_back(far.reply);
      data_in = b1;
      data_wr = 1'b1;
      tick(1);
      data_wr = 1'b0;
      wait_done(n);
      check("byte time", 8'h01, {7'h00, n >= 16 * h && n <= 16 * h + 4});
      tick(20);
      check("far byte", b1, far.got.pop_front());
      check("sticky", 8'h03, {6'h00, flags.transfer_done_flag, event_request});
      event_enable = 1'b0;
      tick(1);
      check("masked", 8'h00, {7'h00, event_request});
      event_enable = 1'b1;
      clear_flags();
      check("cleared", 8'h00, {4'h0, flags});
    end
    // Buffer refilled while shifting at the fastest rate, then one write too many
    far.reply = 8'hFF;
    setup(4'hE, 1'b0, 1'b0, 8'h00);
    b1 = $random(seed);
    b2 = $random(seed);
    exp_q.push_back(far.reply);
    exp_q.push_back(far.reply);
    data_in = b1;
    data_wr = 1'b1;
    tick(1);
    data_wr = 1'b0;
    tick(3);
    data_in = b2;
    data_wr = 1'b1;
    tick(1);
    data_in = 8'hA5;
    tick(1);
    data_wr = 1'b0;
    tick(1);
    check("collision", 8'h01, {7'h00, flags.write_collision_flag});
    for (int k = 0; k < 3000 && far.got.size() < 2; k++) tick(1);
    if (far.got.size() < 2) begin
      errors++;
      report_and_stop();
    end
    tick(8);
    check("far byte", b1, far.got.pop_front());
    check("far byte", b2, far.got.pop_front());
    clear_flags();
    // Another master pulls select low in multi-master mode
    setup(4'hD, 1'b0, 1'b0, 8'h00);
    far.sel_drv = 1'b0;
    tick(6);
    check("fault state", 8'h03, {3'h0, ctrl_out, flags.mode_fault_flag});
    far.sel_drv = 1'b1;
    clear_flags();
    // Three-wire slave: partial byte, re-enable, then fill past the FIFO depth
    setup(4'h8, 1'b0, 1'b0, 8'h00);
    check("select drive", 8'h00, {7'h00, select_oe});
    far.send_bits(8'hFF, 3);
    tick(2);
    write_ctrl(4'h0);
    write_ctrl(4'h8);
    rx_ready = 1'b0;
    for (int k = 0; k < RX_FIFO_DEPTH; k++) begin
      b1 = $random(seed);
      exp_q.push_back(b1);
      far.send_bits(b1, 8);
    end
    far.send_bits(8'h3C, 8);
    tick(6);
    check("slave flags", 8'h09, {4'h0, flags});
    rx_ready = 1'b1;
    for (int k = 0; k < 200 && exp_q.size() > 0; k++) tick(1);
    tick(4);
    check("notes left", 8'h00, 8'(exp_q.size()));
    report_and_stop();
  end
endmodule

// ---- verilog/spi_port.sv ----
// Serial peripheral port: master or slave, three- or four-wire, with a
// receive FIFO. Assumes the bus clock pin is a clock port in slave mode.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////
// Receive FIFO, width and depth as parameters
module spi_rx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clock,               // System clock
  input wire logic rst_n,               // Synchronised reset
  input wire logic in_valid,            // Write request
  output logic in_ready,                // Not full
  input wire logic [WIDTH-1:0] in_data, // Write data
  output logic out_valid,               // Not empty
  input wire logic out_ready,           // Read accept
  output logic [WIDTH-1:0] out_data     // Head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg, rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push, pop;

  // Honest full and empty from the word count
  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr_reg];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Storage has no reset, so it stays a plain memory
  always_ff @(posedge clock) begin
    if (push) mem[wr_ptr_reg] <= in_data;
  end
endmodule

////////////////////////////////////////////////////////////////////////
module spi_port
  import spi_port_pkg::*;
(
  input wire logic clock,                       // System clock, 25 MHz
  input wire logic resetn,                      // Asynchronous reset
  input wire logic ctrl_wr,                     // Control write strobe
  input wire spi_port_pkg::ctrl_t ctrl_in,      // Control write value
  output spi_port_pkg::ctrl_t ctrl_out,         // Control state
  input wire spi_port_pkg::cfg_t cfg,           // Phase, polarity, rate
  input wire logic data_wr,                     // Data write strobe
  input wire logic [7:0] data_in,               // Data to send
  output logic [7:0] rx_data,                   // Received byte
  output logic rx_valid,                        // Received byte present
  input wire logic rx_ready,                    // Received byte taken
  output spi_port_pkg::flags_t flags,           // Event flags
  input wire spi_port_pkg::flags_t flag_clear,  // Per-flag clear pulse
  input wire logic event_enable,                // Event request enable
  output logic event_request,                   // Event request level
  input wire logic serial_clk_in,               // Bus clock pin, slave clock
  output logic sck_out,                         // Bus clock drive
  output logic sck_oe,                          // Bus clock enable
  input wire logic mosi_in,                     // Master-out pin level
  output logic mosi_out,                        // Master-out drive
  output logic mosi_oe,                         // Master-out enable
  input wire logic miso_in,                     // Master-in pin level
  output logic miso_out,                        // Master-in drive
  output logic miso_oe,                         // Master-in enable
  input wire logic slave_select_pin,            // Select pin level
  output logic select_out,                      // Select drive
  output logic select_oe                        // Select enable
);
  import spi_port_pkg::*;

  // Reset release and pin synchronisers
  logic [1:0] rst_sync_reg, sel_sync_reg, miso_sync_reg;
  logic [2:0] done_sync_reg, take_sync_reg;
  logic rst_n;

  ctrl_t ctrl_reg, ctrl_next;
  flags_t flags_reg, flags_next;
  mstate_t state_reg, state_next;
  logic [7:0] tx_buf_reg, tx_buf_next, mshift_reg, mshift_next;
  logic tx_full_reg, tx_full_next, sck_lvl_reg, sck_lvl_next, out_bit_reg, out_bit_next;
  logic [8:0] div_reg, div_next, half_cyc;
  logic [3:0] edge_reg, edge_next;
  logic is_master, three_wire, sel_low, fault, m_done, s_done, take_evt, byte_done;
  logic [7:0] byte_data;
  logic fifo_in_ready;

  // Link-domain state
  logic sample_clk, link_rst_n;
  logic [2:0] cnt_reg, cnt_next;
  logic [7:0] sshift_reg, sshift_next, hold_reg, hold_next;
  logic done_tgl_reg, done_tgl_next, take_tgl_reg, take_tgl_next;

  // Toggle crossing: second stage differs from previous value
  function automatic logic tgl_pulse(input logic [2:0] s);
    tgl_pulse = s[1] ^ s[2];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Reset release and crossings into the system domain
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sel_sync_reg <= 2'h3;
      miso_sync_reg <= 2'h0;
      done_sync_reg <= 3'h0;
      take_sync_reg <= 3'h0;
    end else begin
      sel_sync_reg <= {sel_sync_reg[0], slave_select_pin};
      miso_sync_reg <= {miso_sync_reg[0], miso_in};
      done_sync_reg <= {done_sync_reg[1:0], done_tgl_reg};
      take_sync_reg <= {take_sync_reg[1:0], take_tgl_reg};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode decode
  assign is_master = ctrl_reg.port_enable_bit & ctrl_reg.master_enable_bit;
  assign three_wire = ({ctrl_reg.select_mode_hi_bit, ctrl_reg.select_mode_lo_bit} == SEL_THREE_WIRE);
  assign sel_low = ~sel_sync_reg[1];
  assign fault = is_master & sel_low
    & ({ctrl_reg.select_mode_hi_bit, ctrl_reg.select_mode_lo_bit} == SEL_MULTI_MASTER);
  assign s_done = tgl_pulse(done_sync_reg);
  assign take_evt = tgl_pulse(take_sync_reg);
  // Rate setting only shapes the master clock; never below two cycles a bit
  assign half_cyc = ((9'(cfg.clock_rate) + 9'h001) < 9'(MIN_HALF_CYC)) ? 9'(MIN_HALF_CYC)
                    : 9'(cfg.clock_rate) + 9'h001;

  ////////////////////////////////////////////////////////////////////////
  // System-domain next state: control, transmit buffer, master engine, flags
  always_comb begin
    ctrl_next = ctrl_reg;
    // Software clear first; events below set on top, so a same-cycle set wins
    flags_next = flags_t'(flags_reg & ~flag_clear);
    state_next = state_reg;
    tx_buf_next = tx_buf_reg;
    tx_full_next = tx_full_reg;
    mshift_next = mshift_reg;
    sck_lvl_next = cfg.clock_polarity_bit;
    out_bit_next = out_bit_reg;
    div_next = div_reg;
    edge_next = edge_reg;
    m_done = 1'b0;
    if (ctrl_wr) ctrl_next = ctrl_in;
    // Slave shift register has taken the buffer
    if (take_evt && !is_master) tx_full_next = 1'b0;
    unique case (state_reg)
      M_IDLE: begin
        if (is_master && tx_full_reg) begin
          state_next = M_SHIFT;
          mshift_next = tx_buf_reg;
          out_bit_next = tx_buf_reg[7];
          tx_full_next = 1'b0;
          div_next = 9'h000;
          edge_next = 4'h0;
        end
      end
      M_SHIFT: begin
        sck_lvl_next = sck_lvl_reg;
        div_next = div_reg + 9'h001;
        if (div_reg == half_cyc - 9'h001) begin
          div_next = 9'h000;
          edge_next = edge_reg + 4'h1;
          sck_lvl_next = ~sck_lvl_reg;
          // Phase picks whether leading or trailing edges sample
          if (edge_reg[0] == cfg.clock_phase_bit) begin
            mshift_next = {mshift_reg[6:0], miso_sync_reg[1]};
          end else begin
            out_bit_next = mshift_reg[7];
          end
          if (edge_reg == LAST_EDGE) begin
            state_next = M_IDLE;
            m_done = 1'b1;
          end
        end
        if (!is_master) state_next = M_IDLE;
      end
    endcase
    // A full buffer refuses the write and keeps its byte
    if (data_wr) begin
      if (tx_full_reg) begin
        flags_next.write_collision_flag = 1'b1;
      end else begin
        tx_buf_next = data_in;
        tx_full_next = 1'b1;
      end
    end
    // Another master took the bus: drop out of master mode
    if (fault) begin
      flags_next.mode_fault_flag = 1'b1;
      ctrl_next.master_enable_bit = 1'b0;
      ctrl_next.port_enable_bit = 1'b0;
      state_next = M_IDLE;
    end
    if (byte_done) flags_next.transfer_done_flag = 1'b1;
    if (s_done && !fifo_in_ready) flags_next.receive_overrun_flag = 1'b1;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= ctrl_t'(CTRL_RESET);
      flags_reg <= flags_t'(FLAGS_RESET);
      state_reg <= M_IDLE;
      tx_buf_reg <= DATA_RESET;
      tx_full_reg <= 1'b0;
      mshift_reg <= DATA_RESET;
      sck_lvl_reg <= 1'b0;
      out_bit_reg <= 1'b0;
      div_reg <= 9'h000;
      edge_reg <= 4'h0;
    end else begin
      ctrl_reg <= ctrl_next;
      flags_reg <= flags_next;
      state_reg <= state_next;
      tx_buf_reg <= tx_buf_next;
      tx_full_reg <= tx_full_next;
      mshift_reg <= mshift_next;
      sck_lvl_reg <= sck_lvl_next;
      out_bit_reg <= out_bit_next;
      div_reg <= div_next;
      edge_reg <= edge_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Received bytes into the FIFO; a full FIFO drops the newest byte
  assign byte_done = m_done | s_done;
  assign byte_data = m_done ? mshift_next : hold_reg;

  spi_rx_fifo #(.WIDTH(BYTE_BITS), .DEPTH(RX_FIFO_DEPTH)) rx_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(byte_done),
    .in_ready(fifo_in_ready),
    .in_data(byte_data),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // Slave link domain, clocked by the bus clock pin
  // Polarity and phase fold into one sampling clock; change them only disabled
  assign sample_clk = serial_clk_in ^ cfg.clock_polarity_bit ^ cfg.clock_phase_bit;
  // Three-wire: no pin resets the counter, only a disable does
  assign link_rst_n = rst_n & ctrl_reg.port_enable_bit & ~ctrl_reg.master_enable_bit
                      & (three_wire | ~slave_select_pin);

  always_comb begin
    cnt_next = cnt_reg + 3'h1;
    sshift_next = {sshift_reg[6:0], mosi_in};
    hold_next = hold_reg;
    done_tgl_next = done_tgl_reg;
    take_tgl_next = take_tgl_reg;
    // First bit of a byte: load the transmit buffer, held stable by the full flag
    if (cnt_reg == 3'h0) begin
      sshift_next = {tx_buf_reg[6:0], mosi_in};
      take_tgl_next = ~take_tgl_reg;
    end
    if (cnt_reg == LAST_BIT) begin
      hold_next = sshift_next;
      done_tgl_next = ~done_tgl_reg;
    end
  end

  always_ff @(posedge sample_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      cnt_reg <= 3'h0;
      sshift_reg <= DATA_RESET;
    end else begin
      cnt_reg <= cnt_next;
      sshift_reg <= sshift_next;
    end
  end

  // Toggles and held byte survive the per-byte reset so events are not lost
  always_ff @(posedge sample_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_reg <= DATA_RESET;
      done_tgl_reg <= 1'b0;
      take_tgl_reg <= 1'b0;
    end else begin
      hold_reg <= hold_next;
      done_tgl_reg <= done_tgl_next;
      take_tgl_reg <= take_tgl_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pins and outputs
  assign sck_out = sck_lvl_reg;
  assign sck_oe = is_master;
  assign mosi_out = out_bit_reg;
  assign mosi_oe = is_master;
  assign miso_out = (cnt_reg == 3'h0) ? tx_buf_reg[7] : sshift_reg[7];
  assign miso_oe = ctrl_reg.port_enable_bit & ~ctrl_reg.master_enable_bit & (three_wire | sel_low);
  assign select_out = ctrl_reg.select_mode_lo_bit;
  assign select_oe = ctrl_reg.port_enable_bit & ctrl_reg.select_mode_hi_bit;
  assign ctrl_out = ctrl_reg;
  assign flags = flags_reg;
  assign event_request = event_enable & (flags_reg != flags_t'(FLAGS_RESET));

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_write_collision_flag_drop: assert property (data_wr && tx_full_reg && state_reg == M_SHIFT
    |=> flags_reg.write_collision_flag && tx_buf_reg == $past(tx_buf_reg)) else $error("write not refused");
  a_fault_disable: assert property (fault
    |=> flags_reg.mode_fault_flag && !ctrl_reg.port_enable_bit && !ctrl_reg.master_enable_bit)
    else $error("mode fault missed");
  a_flag_sticky: assert property (flags_reg.mode_fault_flag && !flag_clear.mode_fault_flag
    |=> flags_reg.mode_fault_flag) else $error("flag lost");
  a_done_flag: assert property (byte_done |=> flags_reg.transfer_done_flag) else $error("done not set");
  a_overrun_keep: assert property (s_done && !fifo_in_ready
    |=> flags_reg.receive_overrun_flag && rx_data == $past(rx_data)) else $error("overrun wrong");
  a_event_rise: assert property ($rose(flags_reg.transfer_done_flag) && event_enable
    |-> event_request) else $error("no event request");
  a_master_rate: assert property ($changed(sck_lvl_reg) && state_reg == M_SHIFT
    |-> $past(div_reg) == half_cyc - 9'h001 && half_cyc >= 9'(MIN_HALF_CYC)) else $error("master clock too fast");
  a_master_start: assert property (state_reg == M_IDLE && is_master && tx_full_reg && !fault
    |=> state_reg == M_SHIFT && !tx_full_reg) else $error("transfer not started");
  a_byte_length: assert property ($rose(state_reg == M_SHIFT) && half_cyc == 9'h001 && !fault
    |-> ##15 (m_done || state_reg == M_IDLE)) else $error("byte length wrong");

  c_master_byte: cover property (m_done);
  c_slave_byte: cover property (s_done && fifo_in_ready);
  c_collision: cover property (data_wr && tx_full_reg);
  c_overrun: cover property (s_done && !fifo_in_ready);
endmodule

// ---- verilog/spi_port_pkg.sv ----
// Shared constants and carrier types for the serial peripheral port.
// Assumes a 25 MHz system clock; used by the port top and the testbench.
package spi_port_pkg;

  // System clock and fastest master bit rate, in Hz
  localparam int SYS_CLK_HZ = 25_000_000;
  localparam int MAX_MASTER_BPS = 12_500_000;
  // Least half period of the master serial clock, rounded up
  localparam int MIN_HALF_CYC = (SYS_CLK_HZ + 2 * MAX_MASTER_BPS - 1) / (2 * MAX_MASTER_BPS);

  localparam int BYTE_BITS = 8;
  localparam int RX_FIFO_DEPTH = 32;
  localparam logic [3:0] LAST_EDGE = 4'hF;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Slave-select mode codes
  localparam logic [1:0] SEL_THREE_WIRE = 2'h0;
  localparam logic [1:0] SEL_MULTI_MASTER = 2'h1;

  // Reset values
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  typedef struct packed {
    logic port_enable_bit;
    logic master_enable_bit;
    logic select_mode_hi_bit;
    logic select_mode_lo_bit;
  } ctrl_t;

  typedef struct packed {
    logic clock_phase_bit;
    logic clock_polarity_bit;
    logic [7:0] clock_rate;
  } cfg_t;

  typedef struct packed {
    logic transfer_done_flag;
    logic write_collision_flag;
    logic mode_fault_flag;
    logic receive_overrun_flag;
  } flags_t;

  typedef enum logic [0:0] {
    M_IDLE = 1'b0,
    M_SHIFT = 1'b1
  } mstate_t;

endpackage
